// [hdl/conv_cfg_pkg.sv]
// Notes on behaviour
// - 24-bit reference edge position status readable
// - Position word read-only, reads zero until captured
// - Input A range code, reset 0xA000
// - Input B range code, reset 0xA000
// - Bypass bit 0 selects supply rail reference
// - Timestamp bit 0 enables input receiver
// - Timestamp bit 1 selects PECL signalling
// - Level bits 2:0 drive all 16 lanes
// - Bit 3 adds pre-emphasis boost
package conv_cfg_pkg;

    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned POS_W  = 24;
    localparam int unsigned CELL_W = 16;
    localparam int unsigned NUM_RW = 5;

    // Register indices; the byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_POS     = 10'h02C;
    localparam logic [ADDR_W-1:0] IDX_RANGE_A = 10'h030;
    localparam logic [ADDR_W-1:0] IDX_RANGE_B = 10'h032;
    localparam logic [ADDR_W-1:0] IDX_BYPASS  = 10'h038;
    localparam logic [ADDR_W-1:0] IDX_TSTAMP  = 10'h03B;
    localparam logic [ADDR_W-1:0] IDX_PREEMPH = 10'h048;

    localparam logic [ADDR_W-1:0] ADDR_POS = 10'(IDX_POS * 4);

    localparam int unsigned CELL_RANGE_A = 0;
    localparam int unsigned CELL_RANGE_B = 1;
    localparam int unsigned CELL_BYPASS  = 2;
    localparam int unsigned CELL_TSTAMP  = 3;
    localparam int unsigned CELL_PREEMPH = 4;

    localparam logic [ADDR_W-1:0] RW_ADDR [NUM_RW] = '{
        10'(IDX_RANGE_A * 4), 10'(IDX_RANGE_B * 4), 10'(IDX_BYPASS * 4),
        10'(IDX_TSTAMP * 4), 10'(IDX_PREEMPH * 4)};
    localparam int unsigned RW_WIDTH [NUM_RW] = '{16, 16, 8, 8, 8};
    localparam logic [CELL_W-1:0] RW_RESET [NUM_RW] = '{
        16'hA000, 16'hA000, 16'h0000, 16'h0000, 16'h0000};

    localparam logic [CELL_W-1:0] RANGE_MIN_REC = 16'h2000;

    localparam int unsigned BIT_BYPASS     = 0;
    localparam int unsigned BIT_TS_ENABLE  = 0;
    localparam int unsigned BIT_TS_PECL    = 1;
    localparam int unsigned BIT_PE_BOOST   = 3;
    localparam int unsigned PE_LEVEL_LSB   = 0;
    localparam int unsigned PE_LEVEL_W     = 3;
    localparam int unsigned NUM_LANES      = 16;

    typedef struct packed {
        logic [CELL_W-1:0]     input_a_range_code;
        logic [CELL_W-1:0]     input_b_range_code;
        logic                  reference_bypass_bit;
        logic                  timestamp_receiver_enable;
        logic                  timestamp_pecl_mode;
        logic [PE_LEVEL_W-1:0] lane_preemphasis_level;
        logic                  lane_preemphasis_boost;
    } analog_cfg_t;

    typedef struct packed {
        logic                  boost;
        logic [PE_LEVEL_W-1:0] level;
    } lane_pe_t;

endpackage

// [hdl/cfg_cell.sv]
`timescale 1ns/100ps
`default_nettype none
module cfg_cell #(
    parameter int unsigned     W   = 8,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire logic          we_i,
    input  wire logic [W-1:0]  wd_i,
    output logic      [W-1:0]  q_o
);

    logic [W-1:0] val_q;

    // All bits, reserved ones too, hold what was written
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            val_q <= RST;
        end else if (we_i) begin
            val_q <= wd_i;
        end
    end

    assign q_o = val_q;

endmodule
`default_nettype wire

// [hdl/edge_position_capture.sv]
`timescale 1ns/100ps
`default_nettype none
module edge_position_capture #(
    parameter int unsigned      W = 24
) (
    input  wire logic           mclk_i,
    input  wire logic           rst_n_i,
    input  wire logic           capture_i,
    input  wire logic [W-1:0]   position_i,
    output logic      [W-1:0]   position_o,
    output logic                valid_o
);

    logic [W-1:0] pos_q;
    logic         valid_q;

    // Only the detector loads the word; the bus has no path here
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_q <= '0;
        end else if (capture_i) begin
            pos_q <= position_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_q <= 1'b0;
        end else if (capture_i) begin
            valid_q <= 1'b1;
        end
    end

    assign position_o = pos_q;
    assign valid_o    = valid_q;

endmodule
`default_nettype wire

// [hdl/converter_analog_config_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module converter_analog_config_regs #(
    parameter int unsigned LANES = conv_cfg_pkg::NUM_LANES
) (
    input  wire logic                               mclk_i,
    input  wire logic                               rst_n_i,
    input  wire logic [conv_cfg_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [conv_cfg_pkg::DATA_W-1:0]    wdata_i,
    input  wire logic                               wr_i,
    input  wire logic                               rd_i,
    output logic      [conv_cfg_pkg::DATA_W-1:0]    rdata_o,
    output logic                                    rvalid_o,
    input  wire logic                               edge_capture_i,
    input  wire logic [conv_cfg_pkg::POS_W-1:0]     edge_position_i,
    output logic                                    edge_position_valid_o,
    output conv_cfg_pkg::analog_cfg_t               cfg_o,
    output conv_cfg_pkg::lane_pe_t [LANES-1:0]      lane_pe_o,
    output logic                                    range_a_low_o,
    output logic                                    range_b_low_o
);

    logic [conv_cfg_pkg::CELL_W-1:0] cell_q [conv_cfg_pkg::NUM_RW];
    logic [conv_cfg_pkg::POS_W-1:0]  position;
    logic [conv_cfg_pkg::DATA_W-1:0] rdata_d;
    logic [conv_cfg_pkg::DATA_W-1:0] rdata_q;
    logic                            rvalid_q;
    logic                            pos_valid;

    // Capture word has no write path at all
    edge_position_capture #(
        .W          (conv_cfg_pkg::POS_W)
    ) u_capture (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .capture_i  (edge_capture_i),
        .position_i (edge_position_i),
        .position_o (position),
        .valid_o    (pos_valid)
    );

    genvar g;
    generate
        for (g = 0; g < conv_cfg_pkg::NUM_RW; g++) begin : gen_cell
            localparam int unsigned W = conv_cfg_pkg::RW_WIDTH[g];
            logic [W-1:0] q;
            logic         we;
            assign we = wr_i && (addr_i == conv_cfg_pkg::RW_ADDR[g]);
            cfg_cell #(
                .W       (W),
                .RST     (W'(conv_cfg_pkg::RW_RESET[g]))
            ) u_cell (
                .mclk_i  (mclk_i),
                .rst_n_i (rst_n_i),
                .we_i    (we),
                .wd_i    (wdata_i[W-1:0]),
                .q_o     (q)
            );
            assign cell_q[g] = conv_cfg_pkg::CELL_W'(q);
        end
    endgenerate

    // Read mux; unmapped or misaligned addresses read zero
    always_comb begin
        rdata_d = '0;
        if (addr_i == conv_cfg_pkg::ADDR_POS) begin
            rdata_d = conv_cfg_pkg::DATA_W'(position);
        end
        for (int i = 0; i < conv_cfg_pkg::NUM_RW; i++) begin
            if (addr_i == conv_cfg_pkg::RW_ADDR[i]) begin
                rdata_d = conv_cfg_pkg::DATA_W'(cell_q[i]);
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (rd_i) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_i;
        end
    end

    assign rdata_o  = rdata_q;
    assign rvalid_o = rvalid_q;
    assign edge_position_valid_o = pos_valid;

    // Settings fan out to the analog side
    always_comb begin
        cfg_o.input_a_range_code = cell_q[conv_cfg_pkg::CELL_RANGE_A];
        cfg_o.input_b_range_code = cell_q[conv_cfg_pkg::CELL_RANGE_B];
        cfg_o.reference_bypass_bit =
            cell_q[conv_cfg_pkg::CELL_BYPASS][conv_cfg_pkg::BIT_BYPASS];
        cfg_o.timestamp_receiver_enable =
            cell_q[conv_cfg_pkg::CELL_TSTAMP][conv_cfg_pkg::BIT_TS_ENABLE];
        cfg_o.timestamp_pecl_mode =
            cell_q[conv_cfg_pkg::CELL_TSTAMP][conv_cfg_pkg::BIT_TS_PECL];
        cfg_o.lane_preemphasis_level = cell_q[conv_cfg_pkg::CELL_PREEMPH]
            [conv_cfg_pkg::PE_LEVEL_LSB +: conv_cfg_pkg::PE_LEVEL_W];
        cfg_o.lane_preemphasis_boost =
            cell_q[conv_cfg_pkg::CELL_PREEMPH][conv_cfg_pkg::BIT_PE_BOOST];
    end

    // One shared setting copied to every lane
    generate
        for (g = 0; g < LANES; g++) begin : gen_lane
            assign lane_pe_o[g].level = cfg_o.lane_preemphasis_level;
            assign lane_pe_o[g].boost = cfg_o.lane_preemphasis_boost;
        end
    endgenerate

    // Flags a range code below the recommended minimum
    assign range_a_low_o = cell_q[conv_cfg_pkg::CELL_RANGE_A] < conv_cfg_pkg::RANGE_MIN_REC;
    assign range_b_low_o = cell_q[conv_cfg_pkg::CELL_RANGE_B] < conv_cfg_pkg::RANGE_MIN_REC;

endmodule
`default_nettype wire

// [tb/cfg_regs_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module cfg_regs_monitor #(
    parameter int unsigned LANES = 16
) (
    input wire logic                             mclk_i,
    input wire logic                             rst_n_i,
    input wire logic [9:0]                       addr_i,
    input wire logic [31:0]                      wdata_i,
    input wire logic                             wr_i,
    input wire logic                             rd_i,
    input wire logic [31:0]                      rdata_o,
    input wire logic                             rvalid_o,
    input wire logic                             edge_capture_i,
    input wire logic                             edge_position_valid_o,
    input wire conv_cfg_pkg::analog_cfg_t        cfg_o,
    input wire conv_cfg_pkg::lane_pe_t [LANES-1:0] lane_pe_o,
    input wire logic                             range_a_low_o,
    input wire logic                             range_b_low_o
);
    logic lanes_ok;
    always_comb begin
        lanes_ok = 1'b1;
        for (int i = 0; i < LANES; i++) begin
            if (lane_pe_o[i] != {cfg_o.lane_preemphasis_boost, cfg_o.lane_preemphasis_level}) begin
                lanes_ok = 1'b0;
            end
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_read_data_slot: assert property (rvalid_o == $past(rd_i))
        else $error("read answer not one cycle after strobe");
    a_idle_data_zero: assert property (!rvalid_o |-> rdata_o == '0)
        else $error("read data not zero outside answer");
    a_range_a_write: assert property (wr_i && addr_i == 10'h0C0 |=>
        cfg_o.input_a_range_code == $past(wdata_i[15:0])) else $error("range A write lost");
    a_range_b_write: assert property (wr_i && addr_i == 10'h0C8 |=>
        cfg_o.input_b_range_code == $past(wdata_i[15:0])) else $error("range B write lost");
    a_low_flags_match: assert property ((range_a_low_o == (cfg_o.input_a_range_code < 16'h2000))
        && (range_b_low_o == (cfg_o.input_b_range_code < 16'h2000))) else $error("low flag wrong");
    a_bypass_bit_write: assert property (wr_i && addr_i == 10'h0E0 |=>
        cfg_o.reference_bypass_bit == $past(wdata_i[0])) else $error("bypass write lost");
    a_tstamp_bits_write: assert property (wr_i && addr_i == 10'h0EC |=>
        {cfg_o.timestamp_pecl_mode, cfg_o.timestamp_receiver_enable} == $past(wdata_i[1:0]))
        else $error("timestamp write lost");
    a_preemph_write: assert property (wr_i && addr_i == 10'h120 |=>
        {cfg_o.lane_preemphasis_boost, cfg_o.lane_preemphasis_level} == $past(wdata_i[3:0]))
        else $error("pre-emphasis write lost");
    a_lanes_match_cfg: assert property (lanes_ok)
        else $error("lane setting differs from register");
    a_valid_held_on: assert property (edge_capture_i || edge_position_valid_o |=> edge_position_valid_o)
        else $error("position valid not held");
    a_cfg_kept_still: assert property (!wr_i || addr_i == 10'h0B0 |=> $stable(cfg_o))
        else $error("settings changed without write");
    c_pos_read: cover property (rd_i && addr_i == 10'h0B0);
    c_capture: cover property (edge_capture_i);
    c_low_a: cover property (range_a_low_o);
endmodule
bind converter_analog_config_regs cfg_regs_monitor #(.LANES(LANES)) u_mon (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .edge_capture_i(edge_capture_i), .edge_position_valid_o(edge_position_valid_o),
    .cfg_o(cfg_o), .lane_pe_o(lane_pe_o), .range_a_low_o(range_a_low_o), .range_b_low_o(range_b_low_o));
`default_nettype wire

// [tb/converter_analog_config_regs_test.sv]
`timescale 1ns/100ps
`default_nettype none
module converter_analog_config_regs_test;
    logic                          mclk_i = 1'b0;
    logic                          rst_n_i = 1'b0;
    logic [9:0]                    addr_i = 10'h000;
    logic [31:0]                   wdata_i = 32'h0;
    logic                          wr_i = 1'b0;
    logic                          rd_i = 1'b0;
    logic                          cap_i = 1'b0;
    logic [23:0]                   pos_i = 24'h0;
    logic [31:0]                   rdata_o;
    logic                          rvalid_o;
    logic                          pvalid_o;
    conv_cfg_pkg::analog_cfg_t     cfg_o;
    conv_cfg_pkg::lane_pe_t [15:0] lane_pe_o;
    logic                          lo_a_o;
    logic                          lo_b_o;
    logic [31:0]                   d;
    int                            n_fail = 0;
    int                            checks_done = 0;
    int                            cyc = 0;
    always #5 mclk_i = ~mclk_i;
    converter_analog_config_regs dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .edge_capture_i(cap_i), .edge_position_i(pos_i), .edge_position_valid_o(pvalid_o),
        .cfg_o(cfg_o), .lane_pe_o(lane_pe_o), .range_a_low_o(lo_a_o), .range_b_low_o(lo_b_o));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic t_reset;
        for (int i = 0; i < 5; i++) begin
            rd(conv_cfg_pkg::RW_ADDR[i]);
            chk(d, 32'(conv_cfg_pkg::RW_RESET[i]), "reset value");
        end
        chk(32'(pvalid_o), 32'h0, "position valid after reset");
        $display("reset test done");
    endtask
    task automatic t_rw(input logic [31:0] v);
        for (int i = 0; i < 5; i++) begin
            wr(conv_cfg_pkg::RW_ADDR[i], v);
            rd(conv_cfg_pkg::RW_ADDR[i]);
            chk(d, v & ((32'h1 << conv_cfg_pkg::RW_WIDTH[i]) - 32'h1), "read back");
        end
        chk(32'(cfg_o.input_a_range_code), 32'(v[15:0]), "range A");
        chk(32'(cfg_o.input_b_range_code), 32'(v[15:0]), "range B");
        chk(32'(cfg_o.reference_bypass_bit), 32'(v[0]), "bypass");
        chk(32'({cfg_o.timestamp_pecl_mode, cfg_o.timestamp_receiver_enable}), 32'(v[1:0]), "tstamp");
        chk(32'(cfg_o.lane_preemphasis_level), 32'(v[2:0]), "level");
        chk(32'(cfg_o.lane_preemphasis_boost), 32'(v[3]), "boost");
        chk(32'(lane_pe_o[15]), 32'(v[3:0]), "last lane");
        $display("read write test done");
    endtask
    task automatic t_low;
        wr(10'h0C0, 32'h00001FFF);
        chk(32'(lo_a_o), 32'h1, "A below minimum");
        wr(10'h0C0, 32'h00002000);
        chk(32'(lo_a_o), 32'h0, "A at minimum");
        wr(10'h0C8, 32'h00001FFF);
        chk(32'(lo_b_o), 32'h1, "B below minimum");
        $display("range flag test done");
    endtask
    task automatic t_cap;
        @(posedge mclk_i);
        cap_i <= 1'b1;
        pos_i <= 24'hC3A55A;
        @(posedge mclk_i);
        cap_i <= 1'b0;
        pos_i <= 24'h3C5AA5;
        rd(10'h0B0);
        chk(d, 32'h00C3A55A, "position");
        chk(32'(rvalid_o), 32'h1, "read answer valid");
        chk(32'(pvalid_o), 32'h1, "position valid");
        @(posedge mclk_i);
        #1;
        chk(32'(rvalid_o), 32'h0, "read answer ended");
        chk(rdata_o, 32'h0, "read data cleared");
        wr(10'h0B0, 32'hFFFFFFFF);
        rd(10'h0B0);
        chk(d, 32'h00C3A55A, "position after write");
        wr(10'h3FC, 32'hFFFFFFFF);
        rd(10'h3FC);
        chk(d, 32'h0, "unmapped read");
        rd(10'h0C1);
        chk(d, 32'h0, "misaligned read");
        $display("capture test done");
    endtask
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_rw(32'hFF00A5A5);
        t_rw(32'h00FF5A5A);
        t_low();
        t_cap();
        end_of_test();
    end
endmodule
`default_nettype wire
